// ### inc/pcr_pkg.sv
/*
 * Constants shared by the low-address control register bank and its
 * forwarding link to the VCO subsystem.
 * Assumes one system clock and a host that frames the serial port correctly.
 */
package pcr_pkg;

    // Register addresses
    localparam logic [4:0] ADDR_ID_RDPTR = 5'h00;
    localparam logic [4:0] ADDR_ENABLE = 5'h01;
    localparam logic [4:0] ADDR_REFDIV = 5'h02;
    localparam logic [4:0] ADDR_INTDIV = 5'h03;
    localparam logic [4:0] ADDR_FRACDIV = 5'h04;
    localparam logic [4:0] ADDR_VCO_PORT = 5'h05;

    // Register widths
    localparam int DATA_W = 24;
    localparam int ENABLE_W = 10;
    localparam int REFDIV_W = 14;
    localparam int INTDIV_W = 19;
    localparam int FRACDIV_W = 24;
    localparam int VCO_WORD_W = 16;
    localparam int KEEP_W = 6;

    // Reset values
    localparam logic [9:0] ENABLE_RST = 10'h002;
    localparam logic [13:0] REFDIV_RST = 14'h0001;
    localparam logic [18:0] INTDIV_RST = 19'h0_0019;
    localparam logic [23:0] FRACDIV_RST = 24'h00_0000;
    localparam logic [15:0] VCO_PORT_RST = 16'h0000;

    // Address zero write fields
    localparam int RDPTR_LSB = 0;
    localparam int RDPTR_MSB = 4;
    localparam int SOFT_RESET_BIT = 5;

    // Enable register fields
    localparam int PIN_SELECT_BIT = 0;
    localparam int REG_ENABLE_BIT = 1;
    localparam int KEEP_LSB = 2;
    localparam int KEEP_MSB = 7;

    // Indirect port fields
    localparam int VCO_ID_LSB = 0;
    localparam int VCO_ID_MSB = 2;
    localparam int VCO_RA_LSB = 3;
    localparam int VCO_RA_MSB = 6;
    localparam int VCO_DATA_LSB = 7;
    localparam int VCO_DATA_MSB = 15;
    localparam int VCO_DATA_W = 9;

    // Serial frame: 24 data, 5 address, 3 chip address
    localparam int FRAME_BITS = 32;
    localparam int FRAME_CNT_W = 6;
    localparam int FRAME_ADDR_LSB = 3;
    localparam int FRAME_ADDR_MSB = 7;
    localparam int FRAME_DATA_LSB = 8;
    localparam logic [2:0] CHIP_ADDR = 3'h0;

    // Link rate selector width
    localparam int RATE_W = 2;

endpackage

// ### rtl/pcr_regs.sv
/*
 * Low-address control register bank of the synthesizer: identification,
 * read pointer and soft reset, enable and keep-on bits, the divider words
 * and the indirect VCO port with its forwarding link. Registers are
 * reached over the open-mode serial port pins.
 * Assumes pins are asynchronous to clk_sys and far slower than it.
 */
// Functional notes
// RQ1 - Each indirect port write starts a forward
// RQ2 - Port word: id, register address, data
// RQ3 - Calibration overwrites only the data field
// RQ4 - Host restores address field before recalibration
// RQ5 - Port read returns last forwarded word
// RQ6 - Host rewrites switch settings before reset
// RQ7 - Host clears tune bit for manual reset
// RQ8 - Address zero reads fixed identification code
// RQ9 - Address zero write latches read pointer
// RQ10 - Bit five soft-resets the serial port; code only clears the read pointer to zero
// RQ11 - Enable from pin or register bit
// RQ12 - Keep-on bits hold blocks powered
// RQ13 - Reference divider is fourteen bits
// RQ14 - Host keeps integer divider in range
// RQ15 - Fractional divider is 24-bit unsigned
// RQ16 - Defined reset values for all registers
// RQ17 - Link shifts packet MSB first
// RQ18 - Link rate selected by two bits
// RQ19 - Host waits for forward to finish
`timescale 1ns/1ps

module pcr_regs #(
    // Arbitrary neutral identification value
    parameter logic [23:0] IDENT_CODE = 24'h00_1234
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Serial port pins
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sen,
    output logic sdo,
    output logic sdo_oe,
    // Chip enable pin and derived power controls
    input wire logic chip_enable_pin,
    output logic synth_enable,
    output logic [5:0] block_power,
    // Divider words
    output logic [13:0] ref_divider,
    output logic [18:0] int_divider,
    output logic [23:0] frac_divider,
    // Calibration controller data
    input wire logic cal_load,
    input wire logic [8:0] cal_data,
    // Internal VCO link
    input wire logic [1:0] link_rate_sel,
    output logic vco_link_clk,
    output logic vco_link_data,
    output logic vco_link_frame,
    output logic vco_link_busy
);

    // Two-flop synchronisers: sclk, sdi, sen, chip enable
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic sclk_prev_q;
    logic sen_prev_q;
    logic sclk_s;
    logic sdi_s;
    logic sen_s;
    logic pin_s;
    logic sclk_rise;
    logic sen_rise;
    logic sen_fall;

    logic [31:0] shift_in_q;
    logic [5:0] bit_cnt_q;
    logic [23:0] shift_out_q;
    logic [4:0] rd_ptr_q;

    logic wr_stb;
    logic [4:0] wr_addr;
    logic [23:0] wr_data;
    logic [23:0] rd_data;

    logic [9:0] enable_q;
    logic [13:0] refdiv_q;
    logic [18:0] intdiv_q;
    logic [23:0] fracdiv_q;
    logic [15:0] vco_port_q;
    logic host_port_wr;
    logic fwd_pend_q;
    logic fwd_accept;

    // Reset to idle pin levels (sen high) so no false frame edge follows reset
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= 4'h4;
            sync2_q <= 4'h4;
        end else begin
            sync1_q <= {chip_enable_pin, sen, sdi, sclk};
            sync2_q <= sync1_q;
        end
    end

    assign sclk_s = sync2_q[0];
    assign sdi_s = sync2_q[1];
    assign sen_s = sync2_q[2];
    assign pin_s = sync2_q[3];

    // Idle SEN is high so no frame is seen out of reset
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sclk_prev_q <= 1'b0;
            sen_prev_q <= 1'b1;
        end else begin
            sclk_prev_q <= sclk_s;
            sen_prev_q <= sen_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_prev_q & ~sen_s;
    assign sen_rise = sen_s & ~sen_prev_q;
    assign sen_fall = ~sen_s & sen_prev_q;

    // Frame shifter: data, register address, chip address, MSB first
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            shift_in_q <= 32'h0000_0000;
            bit_cnt_q <= 6'h00;
        end else if (sen_fall) begin
            shift_in_q <= 32'h0000_0000;
            bit_cnt_q <= 6'h00;
        end else if (sclk_rise) begin
            shift_in_q <= {shift_in_q[30:0], sdi_s};
            // Saturate so an overlong frame is not mistaken for a good one
            if (bit_cnt_q != 6'h3F) begin
                bit_cnt_q <= 6'(bit_cnt_q + 6'h01);
            end
        end
    end

    assign wr_addr = shift_in_q[pcr_pkg::FRAME_ADDR_MSB:pcr_pkg::FRAME_ADDR_LSB];
    assign wr_data = shift_in_q[31:pcr_pkg::FRAME_DATA_LSB];
    assign wr_stb = sen_rise
        && (bit_cnt_q == 6'(pcr_pkg::FRAME_BITS))
        && (shift_in_q[2:0] == pcr_pkg::CHIP_ADDR);

    // Read data of the pointed register, loaded when the frame opens
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            shift_out_q <= 24'h00_0000;
        end else if (sen_fall) begin
            shift_out_q <= rd_data;
        end else if (sclk_rise) begin
            shift_out_q <= {shift_out_q[22:0], 1'b0};
        end
    end

    assign sdo = shift_out_q[23];
    assign sdo_oe = ~sen_s;

    // Address zero write: read pointer and soft reset
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rd_ptr_q <= 5'h00;
        end else if (wr_stb && wr_addr == pcr_pkg::ADDR_ID_RDPTR) begin
            if (wr_data[pcr_pkg::SOFT_RESET_BIT]) begin
                rd_ptr_q <= 5'h00; // RQ10
            end else begin
                rd_ptr_q <= wr_data[pcr_pkg::RDPTR_MSB:pcr_pkg::RDPTR_LSB]; // RQ9
            end
        end
    end

    always_comb begin
        if (rd_ptr_q == pcr_pkg::ADDR_ID_RDPTR) begin
            rd_data = IDENT_CODE; // RQ8
        end else if (rd_ptr_q == pcr_pkg::ADDR_ENABLE) begin
            rd_data = {14'h0000, enable_q};
        end else if (rd_ptr_q == pcr_pkg::ADDR_REFDIV) begin
            rd_data = {10'h000, refdiv_q};
        end else if (rd_ptr_q == pcr_pkg::ADDR_INTDIV) begin
            rd_data = {5'h00, intdiv_q};
        end else if (rd_ptr_q == pcr_pkg::ADDR_FRACDIV) begin
            rd_data = fracdiv_q;
        end else if (rd_ptr_q == pcr_pkg::ADDR_VCO_PORT) begin
            rd_data = {8'h00, vco_port_q}; // RQ5
        end else begin
            rd_data = 24'h00_0000;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            enable_q <= pcr_pkg::ENABLE_RST; // RQ16
        end else if (wr_stb && wr_addr == pcr_pkg::ADDR_ENABLE) begin
            enable_q <= wr_data[pcr_pkg::ENABLE_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            refdiv_q <= pcr_pkg::REFDIV_RST; // RQ16
        end else if (wr_stb && wr_addr == pcr_pkg::ADDR_REFDIV) begin
            refdiv_q <= wr_data[pcr_pkg::REFDIV_W-1:0]; // RQ13
        end
    end

    // Range of the integer word is the host's to respect
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            intdiv_q <= pcr_pkg::INTDIV_RST; // RQ16
        end else if (wr_stb && wr_addr == pcr_pkg::ADDR_INTDIV) begin
            intdiv_q <= wr_data[pcr_pkg::INTDIV_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fracdiv_q <= pcr_pkg::FRACDIV_RST; // RQ16
        end else if (wr_stb && wr_addr == pcr_pkg::ADDR_FRACDIV) begin
            fracdiv_q <= wr_data[pcr_pkg::FRACDIV_W-1:0]; // RQ15
        end
    end

    assign host_port_wr = wr_stb && (wr_addr == pcr_pkg::ADDR_VCO_PORT);

    // Host write wins over a calibration update in the same cycle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            vco_port_q <= pcr_pkg::VCO_PORT_RST; // RQ16
        end else if (host_port_wr) begin
            vco_port_q <= wr_data[pcr_pkg::VCO_WORD_W-1:0]; // RQ2
        end else if (cal_load) begin
            vco_port_q[pcr_pkg::VCO_DATA_MSB:pcr_pkg::VCO_DATA_LSB] <= cal_data; // RQ3
        end
    end

    // Pending forward; a new request wins over the accept
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fwd_pend_q <= 1'b0;
        end else begin
            fwd_pend_q <= host_port_wr | cal_load | (fwd_pend_q & ~fwd_accept); // RQ1
        end
    end

    // A write landing mid-transfer is sent afterwards with the latest word
    assign fwd_accept = fwd_pend_q & ~vco_link_busy;

    pcr_vco_link_tx #(
        .WIDTH(pcr_pkg::VCO_WORD_W)
    ) u_link (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .start(fwd_accept),
        .word(vco_port_q),
        .rate_sel(link_rate_sel), // RQ18
        .busy(vco_link_busy),
        .link_clk(vco_link_clk),
        .link_data(vco_link_data),
        .link_frame(vco_link_frame)
    );

    assign synth_enable = enable_q[pcr_pkg::PIN_SELECT_BIT]
        ? pin_s : enable_q[pcr_pkg::REG_ENABLE_BIT]; // RQ11
    assign block_power = {pcr_pkg::KEEP_W{synth_enable}}
        | enable_q[pcr_pkg::KEEP_MSB:pcr_pkg::KEEP_LSB]; // RQ12
    assign ref_divider = refdiv_q;
    assign int_divider = intdiv_q;
    assign frac_divider = fracdiv_q;

endmodule

// ### rtl/pcr_vco_link_tx.sv
/*
 * Serialiser that forwards one indirect port word to the VCO subsystem,
 * MSB first, with a divided link clock.
 * Assumes start is a one-cycle pulse given only while busy is low.
 */
`timescale 1ns/1ps

module pcr_vco_link_tx #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Request side
    input wire logic start,
    input wire logic [WIDTH-1:0] word,
    input wire logic [1:0] rate_sel,
    output logic busy,
    // Link pins
    output logic link_clk,
    output logic link_data,
    output logic link_frame
);

    typedef enum logic [0:0] {
        PCR_LINK_IDLE = 1'b0,
        PCR_LINK_SHIFT = 1'b1
    } pcr_link_e;

    pcr_link_e state_q;
    logic [WIDTH-1:0] shreg_q;
    logic [7:0] bit_q;
    logic [3:0] div_q;
    logic clk_q;
    logic [3:0] half_period;

    // Half period of 1, 2, 4 or 8 system cycles
    assign half_period = 4'(4'h1 << rate_sel);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q <= PCR_LINK_IDLE;
            shreg_q <= '0;
            bit_q <= 8'h00;
            div_q <= 4'h0;
            clk_q <= 1'b0;
        end else begin
            case (state_q)
                PCR_LINK_IDLE: begin
                    clk_q <= 1'b0;
                    if (start) begin
                        state_q <= PCR_LINK_SHIFT;
                        shreg_q <= word;
                        bit_q <= 8'h00;
                        div_q <= 4'(half_period - 4'h1);
                    end
                end
                PCR_LINK_SHIFT: begin
                    if (div_q == 4'h0) begin
                        div_q <= 4'(half_period - 4'h1);
                        clk_q <= ~clk_q;
                        // Data moves on the falling edge, stable at the rising one
                        if (clk_q) begin
                            if (bit_q == 8'(WIDTH - 1)) begin
                                state_q <= PCR_LINK_IDLE;
                            end else begin
                                shreg_q <= {shreg_q[WIDTH-2:0], 1'b0}; // RQ17
                                bit_q <= 8'(bit_q + 8'h01);
                            end
                        end
                    end else begin
                        div_q <= 4'(div_q - 4'h1);
                    end
                end
                default: begin
                    state_q <= PCR_LINK_IDLE;
                end
            endcase
        end
    end

    assign busy = (state_q == PCR_LINK_SHIFT);
    assign link_clk = clk_q;
    assign link_data = shreg_q[WIDTH-1]; // RQ17
    assign link_frame = (state_q == PCR_LINK_SHIFT);

endmodule

// ### sim/pcr_chk.sv
/*
 * Port checker for the control register bank and its VCO link.
 * Assumes binding to pcr_regs and one clock domain.
 */
`timescale 1ns/1ps

module pcr_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Serial port
    input wire logic sen,
    input wire logic sdo_oe,
    // Power controls
    input wire logic synth_enable,
    input wire logic [5:0] block_power,
    // Divider words
    input wire logic [13:0] ref_divider,
    input wire logic [18:0] int_divider,
    input wire logic [23:0] frac_divider,
    // Calibration and link
    input wire logic cal_load,
    input wire logic [1:0] link_rate_sel,
    input wire logic vco_link_clk,
    input wire logic vco_link_data,
    input wire logic vco_link_frame,
    input wire logic vco_link_busy
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    // Cycles the current link frame has been high
    logic [9:0] len_q;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            len_q <= 10'h000;
        end else begin
            len_q <= vco_link_frame ? len_q + 10'h001 : 10'h000;
        end
    end

    chk_frame_len: assert property (
        $fell(vco_link_frame) |-> len_q == (10'h020 << link_rate_sel))
        else $error("link frame length wrong");
    chk_link_toggle: assert property (
        vco_link_frame && $past(vco_link_frame) && link_rate_sel == 2'h0
        && $past(link_rate_sel) == 2'h0 |-> vco_link_clk != $past(vco_link_clk))
        else $error("link clock not toggling");
    chk_clk_idle: assert property (
        !vco_link_frame |-> !vco_link_clk)
        else $error("link clock runs outside frame");
    chk_data_hold: assert property (
        vco_link_frame && $past(vco_link_frame) && !$fell(vco_link_clk)
        |-> $stable(vco_link_data))
        else $error("link data moved off falling edge");
    chk_cal_forward: assert property (
        cal_load && !vco_link_busy |-> ##[1:4] vco_link_frame)
        else $error("calibration load not forwarded");
    chk_keep_power: assert property (
        synth_enable |-> block_power == 6'h3f)
        else $error("block powered down while enabled");
    chk_div_hold: assert property (
        !sen [*8] |=> $stable(ref_divider) && $stable(int_divider) && $stable(frac_divider))
        else $error("divider changed inside frame");
    chk_oe_on: assert property (
        !sen [*3] |-> sdo_oe)
        else $error("read output not driven in frame");
    chk_oe_off: assert property (
        sen [*3] |-> !sdo_oe)
        else $error("read output driven when idle");

    cov_cal: cover property (cal_load && !vco_link_busy);
    cov_slow: cover property ($fell(vco_link_frame) && link_rate_sel == 2'h3);
    cov_off: cover property (!synth_enable && block_power != 6'h00);
endmodule

// ### sim/pcr_host.sv
/*
 * Host model that frames the open-mode serial port.
 * Assumes clk_sys is the bank's clock; pin edges are four cycles apart.
 */
`timescale 1ns/1ps

module pcr_host (
    // Clock
    input wire logic clk_sys,
    // Serial port pins
    output logic sclk,
    output logic sdi,
    output logic sen,
    input wire logic sdo
);
    initial begin
        sclk = 1'b0;
        sdi = 1'b0;
        sen = 1'b1;
    end

    // One 32-bit frame; rd holds the first 24 bits seen on sdo
    task automatic xfer(input logic [23:0] d, input logic [4:0] a, output logic [23:0] rd);
        logic [31:0] f;
        f = {d, a, 3'h0};
        sen <= 1'b0;
        repeat (4) @(posedge clk_sys);
        for (int i = 31; i >= 0; i--) begin
            sdi <= f[i];
            repeat (4) @(posedge clk_sys);
            if (i > 7) begin
                rd[i-8] = sdo;
            end
            sclk <= 1'b1;
            repeat (4) @(posedge clk_sys);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge clk_sys);
        sen <= 1'b1;
        // Released line must not keep its last level
        sdi <= ~f[0];
        repeat (8) @(posedge clk_sys);
    endtask

    // Two-cycle read: pointer frame, then the same frame again
    task automatic rdreg(input logic [4:0] a, output logic [23:0] rd);
        xfer({19'h0_0000, a}, 5'h00, rd);
        xfer({19'h0_0000, a}, 5'h00, rd);
    endtask
endmodule

// ### sim/tb_top.sv
/*
 * Self-checking bench for the control register bank.
 * Assumes the checker and host model are compiled before it.
 */
`timescale 1ns/1ps

module tb_top;
    // Arbitrary identification value
    localparam logic [23:0] ID_V = 24'h00_5A5A;
    logic clk_sys = 1'b0;
    logic nrst, sclk, sdi, sen, sdo, sdo_oe, chip_enable_pin, synth_enable, cal_load;
    logic vco_link_clk, vco_link_data, vco_link_frame, vco_link_busy;
    logic [5:0] block_power;
    logic [13:0] ref_divider;
    logic [18:0] int_divider;
    logic [23:0] frac_divider, rv;
    logic [8:0] cal_data;
    logic [1:0] link_rate_sel;
    logic [15:0] lnk_q;
    int failures = 0;
    int n_compared = 0;

    always #25 clk_sys = ~clk_sys;
    // Link bits are settled at the rising link clock
    always @(posedge vco_link_clk) begin
        lnk_q <= {lnk_q[14:0], vco_link_data};
    end

    pcr_host host (.clk_sys(clk_sys), .sclk(sclk), .sdi(sdi), .sen(sen), .sdo(sdo));
    pcr_regs #(.IDENT_CODE(ID_V)) uut (
        .clk_sys(clk_sys), .nrst(nrst), .sclk(sclk), .sdi(sdi), .sen(sen), .sdo(sdo),
        .sdo_oe(sdo_oe), .chip_enable_pin(chip_enable_pin), .synth_enable(synth_enable),
        .block_power(block_power), .ref_divider(ref_divider), .int_divider(int_divider),
        .frac_divider(frac_divider), .cal_load(cal_load), .cal_data(cal_data),
        .link_rate_sel(link_rate_sel), .vco_link_clk(vco_link_clk),
        .vco_link_data(vco_link_data), .vco_link_frame(vco_link_frame),
        .vco_link_busy(vco_link_busy));

    task automatic end_sim;
        if (failures == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [23:0] exp);
        host.rdreg(a, rv);
        cmp(rv, exp);
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        repeat (4) @(posedge clk_sys);
        while (vco_link_busy !== 1'b0) begin
            @(posedge clk_sys);
            n++;
            if (n > 600) begin
                failures++;
                $display("wrong value at %0t: link never idle", $time);
                end_sim();
            end
        end
    endtask

    task automatic t_reset;
        logic [23:0] exp [6];
        exp = '{ID_V, 24'h00_0002, 24'h00_0001, 24'h00_0019, 24'h00_0000, 24'h00_0000};
        for (int a = 0; a < 6; a++) begin
            rd_chk(a[4:0], exp[a]);
        end
    endtask

    task automatic t_regs;
        host.xfer(24'hFF_FFFF, pcr_pkg::ADDR_REFDIV, rv);
        rd_chk(pcr_pkg::ADDR_REFDIV, 24'h00_3FFF);
        cmp({10'h000, ref_divider}, 24'h00_3FFF);
        host.xfer(24'h07_FFFC, pcr_pkg::ADDR_INTDIV, rv);
        cmp({5'h00, int_divider}, 24'h07_FFFC);
        host.xfer(24'h00_0014, pcr_pkg::ADDR_INTDIV, rv);
        rd_chk(pcr_pkg::ADDR_INTDIV, 24'h00_0014);
        host.xfer(24'hFF_FFFF, pcr_pkg::ADDR_FRACDIV, rv);
        cmp(frac_divider, 24'hFF_FFFF);
        host.xfer(24'h00_0003, pcr_pkg::ADDR_ID_RDPTR, rv);
        rd_chk(pcr_pkg::ADDR_ID_RDPTR, ID_V);
        host.xfer(24'h12_3456, 5'h06, rv);
        rd_chk(5'h06, 24'h00_0000);
    endtask

    task automatic t_enable;
        host.xfer(24'h00_0000, pcr_pkg::ADDR_ENABLE, rv);
        cmp({17'h0_0000, synth_enable, block_power}, 24'h00_0000);
        for (int i = 0; i < 6; i++) begin
            host.xfer(24'h00_0004 << i, pcr_pkg::ADDR_ENABLE, rv);
            cmp({18'h0_0000, block_power}, 24'h00_0001 << i);
        end
        host.xfer(24'h00_0001, pcr_pkg::ADDR_ENABLE, rv);
        chip_enable_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        cmp({17'h0_0000, synth_enable, block_power}, 24'h00_007F);
        chip_enable_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        cmp({23'h00_0000, synth_enable}, 24'h00_0000);
        host.xfer(24'h00_0002, pcr_pkg::ADDR_ENABLE, rv);
    endtask

    task automatic t_link;
        // First word is a manual reset: tune off, caps, VCO select
        logic [15:0] w [4];
        logic [7:0] sw;
        // Switch settings fixed in the bench for the manual reset
        sw = 8'hAA;
        w = '{{sw, 8'h00}, 16'h7F91, 16'h0FF6, 16'hC35A};
        for (int s = 0; s < 4; s++) begin
            link_rate_sel <= s[1:0];
            host.xfer({8'h00, w[s]}, pcr_pkg::ADDR_VCO_PORT, rv);
            wait_idle();
            cmp({8'h00, lnk_q}, {8'h00, w[s]});
            rd_chk(pcr_pkg::ADDR_VCO_PORT, {8'h00, w[s]});
        end
        link_rate_sel <= 2'h0;
    endtask

    task automatic t_cal;
        logic [6:0] hd [2];
        hd = '{7'h05, 7'h33};
        for (int k = 0; k < 2; k++) begin
            host.xfer({17'h0_0000, hd[k]}, pcr_pkg::ADDR_VCO_PORT, rv);
            wait_idle();
            cal_data <= 9'h1A5 ^ 9'(k);
            cal_load <= 1'b1;
            @(posedge clk_sys);
            cal_load <= 1'b0;
            wait_idle();
            cmp({8'h00, lnk_q}, {8'h00, 9'h1A5 ^ 9'(k), hd[k]});
            rd_chk(pcr_pkg::ADDR_VCO_PORT, {8'h00, 9'h1A5 ^ 9'(k), hd[k]});
        end
    endtask

    task automatic t_soft;
        host.xfer(24'h00_0003, pcr_pkg::ADDR_ID_RDPTR, rv);
        host.xfer(24'h00_0020, pcr_pkg::ADDR_ID_RDPTR, rv);
        cmp(rv, 24'h00_0014);
        host.xfer(24'h00_0000, 5'h07, rv);
        cmp(rv, ID_V);
    endtask

    initial begin
        nrst = 1'b0;
        chip_enable_pin = 1'b0;
        cal_load = 1'b0;
        cal_data = 9'h000;
        link_rate_sel = 2'h0;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_regs();
        t_enable();
        t_link();
        t_cal();
        t_soft();
        end_sim();
    end
endmodule

bind pcr_regs pcr_chk chk (
    .clk_sys(clk_sys), .nrst(nrst), .sen(sen), .sdo_oe(sdo_oe),
    .synth_enable(synth_enable), .block_power(block_power), .ref_divider(ref_divider),
    .int_divider(int_divider), .frac_divider(frac_divider), .cal_load(cal_load),
    .link_rate_sel(link_rate_sel), .vco_link_clk(vco_link_clk),
    .vco_link_data(vco_link_data), .vco_link_frame(vco_link_frame),
    .vco_link_busy(vco_link_busy));
